// file: verilog/core_regs_params.svh
`ifndef CORE_REGS_PARAMS_SVH
`define CORE_REGS_PARAMS_SVH

// Direct special-register addresses
`define ADDR_STACK_POINTER 8'h81
`define ADDR_DATA_PTR_LOW 8'h82
`define ADDR_DATA_PTR_HIGH 8'h83
`define ADDR_POWER_CONTROL 8'h87
`define ADDR_EXT_PORT_CONFIG 8'h9f
`define ADDR_CORE_CONFIG 8'haf
`define ADDR_STATUS_WORD 8'hd0
`define ADDR_ACCUMULATOR 8'he0
`define ADDR_B_REG 8'hf0

// Bit addresses 0xd0..0xd7 reach the status word, upper five bits match this
`define STATUS_BIT_BLOCK 5'h1a

// Reset values
`define RST_STACK_POINTER 8'h07
`define RST_DATA_PTR 16'h0000
`define RST_POWER_CONTROL 8'h00
`define RST_CORE_CONFIG 8'h81
`define RST_EXT_PORT_CONFIG 8'h00
`define RST_STATUS_WORD 7'h00
`define RST_BYTE 8'h00
`define RST_PROGRAM_COUNTER 16'h0000
`define RST_OPCODE 8'h00

// Power-control field
`define BIT_BAUD_DOUBLE 7

// Core-config fields
`define BIT_CFG_KEEP_SET 7
`define BIT_UART_CHECK 6
`define BIT_SYNC_SEL 5
`define BIT_CARRIER_EN 4
`define FLD_XRAM_HI 1
`define FLD_XRAM_LO 0

// Status-word fields
`define BIT_CARRY 7
`define BIT_AUX_CARRY 6
`define BIT_USER_F0 5
`define BIT_BANK_HI 4
`define BIT_BANK_LO 3
`define BIT_OVERFLOW 2
`define BIT_USER_F1 1
`define BIT_PARITY 0

// Working register banks
`define BANK_REGS 8
`define BANK_COUNT 4

// Operation lengths in clock cycles
`define CYC_REG_OP 2'h1
`define CYC_MEM_OP 2'h2

`endif

// file: verilog/core_regs_pkg.sv
package core_regs_pkg;

  typedef struct packed {
    logic baud_double;
    logic uart_checking_enable;
    logic sync_port_select;
    logic carrier_mod_enable;
    logic [1:0] xram_access_enable;
  } mode_bits_t;

  typedef struct packed {
    logic carry;
    logic aux_carry;
    logic overflow;
  } flag_upd_t;

  typedef enum logic [1:0] {
    src_work_reg,
    src_literal,
    src_ram
  } op_src_t;

endpackage

// file: verilog/working_bank.sv
`include "core_regs_params.svh"

module working_bank #(
  parameter int ENTRIES = `BANK_REGS,
  parameter int BANKS = `BANK_COUNT,
  localparam int IW = $clog2(ENTRIES),
  localparam int BW = $clog2(BANKS),
  localparam int AW = IW + BW
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [BW-1:0] bank_sel,
  input wire logic [IW-1:0] reg_idx,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic [AW-1:0] reg_ram_addr,
  input wire logic [AW-1:0] direct_addr,
  input wire logic direct_wr,
  input wire logic [7:0] direct_wdata,
  output logic [7:0] direct_rdata
);

  logic [7:0] mem_q [BANKS*ENTRIES];

  // Register n of bank k sits at RAM byte k*8+n
  assign reg_ram_addr = {bank_sel, reg_idx};
  assign reg_rdata = mem_q[reg_ram_addr];
  assign direct_rdata = mem_q[direct_addr];

  // The working-register port wins a same-byte collision with the direct port
  for (genvar i = 0; i < BANKS * ENTRIES; i++)
  begin : g_entry
    wire logic hit_reg = reg_wr && (reg_ram_addr == AW'(i));
    wire logic hit_dir = direct_wr && (direct_addr == AW'(i));
    always_ff @(posedge clk or negedge arst_n)
    begin
      if (!arst_n)
        mem_q[i] <= `RST_BYTE;
      else if (ce && (hit_reg || hit_dir))
        mem_q[i] <= hit_reg ? reg_wdata : direct_wdata;
    end
  end

  bank_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    ce && reg_wr |=> mem_q[$past(reg_ram_addr)] == $past(reg_wdata))
    else $error("working register write did not land at bank*8+n");

endmodule

// file: verilog/pc_unit.sv
`include "core_regs_params.svh"

module pc_unit (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic pc_advance,
  input wire logic [1:0] instr_len,
  input wire logic pc_load,
  input wire logic [15:0] pc_target,
  input wire logic opcode_load,
  input wire logic [7:0] opcode_in,
  output logic [15:0] program_counter,
  output logic [7:0] opcode_holder
);

  logic [15:0] pc_q;
  logic [15:0] pc_d;
  logic [7:0] op_q;

  // A length of zero is not an instruction; treat it as one byte
  wire logic [1:0] step = (instr_len == 2'h0) ? 2'h1 : instr_len;

  // Jumps and calls take priority over the sequential advance
  assign pc_d = pc_load ? pc_target : pc_q + {14'h0000, step};

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pc_q <= `RST_PROGRAM_COUNTER;
    else if (ce && (pc_load || pc_advance))
      pc_q <= pc_d;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      op_q <= `RST_OPCODE;
    else if (ce && opcode_load)
      op_q <= opcode_in;
  end

  assign program_counter = pc_q;
  assign opcode_holder = op_q;

  pc_advance_a: assert property (@(posedge clk) disable iff (!arst_n)
    ce && pc_advance && !pc_load && instr_len != 2'h0
      |=> pc_q == $past(pc_q) + {14'h0000, $past(instr_len)})
    else $error("program counter did not advance by instruction length");

  pc_jump_a: assert property (@(posedge clk) disable iff (!arst_n)
    ce && pc_load |=> pc_q == $past(pc_target))
    else $error("program counter did not take jump target");

  opcode_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    !(ce && opcode_load) |=> $stable(op_q))
    else $error("opcode holder changed without a load");

endmodule

// file: verilog/core_special_regs.sv
// Contract
// - Power-control bit 7 doubles serial baud rate; resets to 0.
// - Data pointer: high byte 0x83, low 0x82, word or bytes, reset zero.
// - Stack pointer is an 8-bit register resetting to 7.
// - Config bit 6 enables enhanced UART checking; reset 0.
// - Config bit 5 gives shared pins to I2C at 0, SPI at 1.
// - Config bit 4 applies carrier modulation on pins chosen by pin select.
// - MOVX to extended RAM enabled when either config bit 1:0 set; reset 01.
// - Program counter clears at reset, advances by instruction length 1..3.
// - Program counter is not a register; calls and jumps load it.
// - Internal opcode holder keeps executing opcode, hidden from software.
// - Four banks of eight working bytes fill lowest 32 RAM bytes.
// - Accumulator-register operation takes one cycle; literal or RAM two.
// - Active bank chosen by two bank-select bits in status word 0xd0.
// - Parity flag follows accumulator set-bit count without instructions.
// - B register feeds multiply and divide, else scratch byte.
// - Status word shows carry, aux carry, overflow; bits individually writable (here bit 0, parity, ignores byte and bit writes).
// - Data pointer is address source for code and data memory access.
// - Bank-select bits 4:3 encode bank number directly.
`include "core_regs_params.svh"

module core_special_regs (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic bit_wr,
  input wire logic [7:0] bit_addr,
  input wire logic bit_val,
  input wire logic acc_wr,
  input wire logic [7:0] acc_in,
  input wire logic b_wr,
  input wire logic [7:0] b_in,
  input wire logic flags_wr,
  input wire core_regs_pkg::flag_upd_t flags_in,
  input wire logic data_pointer_word_load,
  input wire logic [15:0] data_pointer_word_in,
  input wire logic data_pointer_word_inc,
  input wire logic stack_load,
  input wire logic [7:0] stack_in,
  input wire logic pc_advance,
  input wire logic [1:0] instr_len,
  input wire logic pc_load,
  input wire logic [15:0] pc_target,
  input wire logic opcode_load,
  input wire logic [7:0] opcode_in,
  input wire logic [2:0] wreg_idx,
  input wire logic wreg_wr,
  input wire logic [7:0] wreg_wdata,
  output logic [7:0] wreg_rdata,
  output logic [4:0] wreg_ram_addr,
  input wire logic [4:0] ram_lo_addr,
  input wire logic ram_lo_wr,
  input wire logic [7:0] ram_lo_wdata,
  output logic [7:0] ram_lo_rdata,
  input wire core_regs_pkg::op_src_t operand_src,
  output logic [1:0] op_cycles,
  output logic [7:0] accumulator,
  output logic [7:0] b_operand,
  output logic [7:0] status_word,
  output logic [15:0] data_pointer_word,
  output logic [7:0] stack_pointer,
  output logic [15:0] program_counter,
  output logic [7:0] opcode_holder,
  output core_regs_pkg::mode_bits_t mode_bits,
  output logic [7:0] carrier_pin_mask,
  output logic movx_enable
);

  logic [7:0] acc_q;
  logic [7:0] b_q;
  logic [7:1] psw_q;
  logic [7:1] psw_d;
  logic [15:0] data_pointer_word_q;
  logic [15:0] data_pointer_word_d;
  logic [7:0] sp_q;
  logic baud_q;
  logic [7:0] cfg_q;
  logic [7:0] epc_q;
  logic [7:0] rdata_q;

  // Write decode
  wire logic wr_sp = sfr_wr && (sfr_addr == `ADDR_STACK_POINTER);
  wire logic wr_dpl = sfr_wr && (sfr_addr == `ADDR_DATA_PTR_LOW);
  wire logic wr_dph = sfr_wr && (sfr_addr == `ADDR_DATA_PTR_HIGH);
  wire logic wr_power_control = sfr_wr && (sfr_addr == `ADDR_POWER_CONTROL);
  wire logic wr_epc = sfr_wr && (sfr_addr == `ADDR_EXT_PORT_CONFIG);
  wire logic wr_cfg = sfr_wr && (sfr_addr == `ADDR_CORE_CONFIG);
  wire logic wr_psw = sfr_wr && (sfr_addr == `ADDR_STATUS_WORD);
  wire logic wr_acc = sfr_wr && (sfr_addr == `ADDR_ACCUMULATOR);
  wire logic wr_b = sfr_wr && (sfr_addr == `ADDR_B_REG);
  wire logic bit_psw = bit_wr && (bit_addr[7:3] == `STATUS_BIT_BLOCK);

  // Parity is derived, never stored, so it can not lag the accumulator
  wire logic parity = ^acc_q;
  wire logic [7:0] psw_full = {psw_q, parity};
  wire logic [1:0] bank_sel = psw_q[`BIT_BANK_HI:`BIT_BANK_LO];

  // Read mux; unmapped addresses read zero
  wire logic [7:0] rd_mux =
    (sfr_addr == `ADDR_STACK_POINTER) ? sp_q :
    (sfr_addr == `ADDR_DATA_PTR_LOW) ? data_pointer_word_q[7:0] :
    (sfr_addr == `ADDR_DATA_PTR_HIGH) ? data_pointer_word_q[15:8] :
    (sfr_addr == `ADDR_POWER_CONTROL) ? {baud_q, 7'h00} :
    (sfr_addr == `ADDR_EXT_PORT_CONFIG) ? epc_q :
    (sfr_addr == `ADDR_CORE_CONFIG) ? cfg_q :
    (sfr_addr == `ADDR_STATUS_WORD) ? psw_full :
    (sfr_addr == `ADDR_ACCUMULATOR) ? acc_q :
    (sfr_addr == `ADDR_B_REG) ? b_q : 8'h00;

  // Status word: byte write, then bit write, then ALU flags on top, so a flag
  // produced by an instruction is never lost to a concurrent software write
  always_comb
  begin
    psw_d = psw_q;
    if (wr_psw)
      psw_d = sfr_wdata[7:1];
    if (bit_psw && bit_addr[2:0] != 3'h0)
      psw_d[bit_addr[2:0]] = bit_val;
    if (flags_wr)
    begin
      psw_d[`BIT_CARRY] = flags_in.carry;
      psw_d[`BIT_AUX_CARRY] = flags_in.aux_carry;
      psw_d[`BIT_OVERFLOW] = flags_in.overflow;
    end
  end

  // Data pointer: word load or increment, then byte writes override per half
  always_comb
  begin
    data_pointer_word_d = data_pointer_word_q;
    if (data_pointer_word_load)
      data_pointer_word_d = data_pointer_word_in;
    else if (data_pointer_word_inc)
      data_pointer_word_d = data_pointer_word_q + 16'h0001;
    if (wr_dpl)
      data_pointer_word_d[7:0] = sfr_wdata;
    if (wr_dph)
      data_pointer_word_d[15:8] = sfr_wdata;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      psw_q <= `RST_STATUS_WORD;
    else if (ce)
      psw_q <= psw_d;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      data_pointer_word_q <= `RST_DATA_PTR;
    else if (ce)
      data_pointer_word_q <= data_pointer_word_d;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      sp_q <= `RST_STACK_POINTER;
    else if (ce && (wr_sp || stack_load))
      sp_q <= wr_sp ? sfr_wdata : stack_in;
  end

  // Software writes take priority over the execution path
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      acc_q <= `RST_BYTE;
    else if (ce && (wr_acc || acc_wr))
      acc_q <= wr_acc ? sfr_wdata : acc_in;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      b_q <= `RST_BYTE;
    else if (ce && (wr_b || b_wr))
      b_q <= wr_b ? sfr_wdata : b_in;
  end

  // Reserved power-control bits are not stored and read back as zero
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      baud_q <= 1'(`RST_POWER_CONTROL >> `BIT_BAUD_DOUBLE);
    else if (ce && wr_power_control)
      baud_q <= sfr_wdata[`BIT_BAUD_DOUBLE];
  end

  // Reserved config bits are stored as written so software reads its own value
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cfg_q <= `RST_CORE_CONFIG;
    else if (ce && wr_cfg)
      cfg_q <= sfr_wdata;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      epc_q <= `RST_EXT_PORT_CONFIG;
    else if (ce && wr_epc)
      epc_q <= sfr_wdata;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata_q <= `RST_BYTE;
    else if (ce && sfr_rd)
      rdata_q <= rd_mux;
  end

  pc_unit u_pc (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .pc_advance(pc_advance),
    .instr_len(instr_len),
    .pc_load(pc_load),
    .pc_target(pc_target),
    .opcode_load(opcode_load),
    .opcode_in(opcode_in),
    .program_counter(program_counter),
    .opcode_holder(opcode_holder)
  );

  working_bank #(
    .ENTRIES(`BANK_REGS),
    .BANKS(`BANK_COUNT)
  ) u_bank (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .bank_sel(bank_sel),
    .reg_idx(wreg_idx),
    .reg_wr(wreg_wr),
    .reg_wdata(wreg_wdata),
    .reg_rdata(wreg_rdata),
    .reg_ram_addr(wreg_ram_addr),
    .direct_addr(ram_lo_addr),
    .direct_wr(ram_lo_wr),
    .direct_wdata(ram_lo_wdata),
    .direct_rdata(ram_lo_rdata)
  );

  // Register operands come straight from the bank flops, hence one cycle
  assign op_cycles = (operand_src == core_regs_pkg::src_work_reg) ? `CYC_REG_OP
    : `CYC_MEM_OP;

  assign sfr_rdata = rdata_q;
  assign accumulator = acc_q;
  assign b_operand = b_q;
  assign status_word = psw_full;
  assign data_pointer_word = data_pointer_word_q;
  assign stack_pointer = sp_q;
  assign mode_bits.baud_double = baud_q;
  assign mode_bits.uart_checking_enable = cfg_q[`BIT_UART_CHECK];
  assign mode_bits.sync_port_select = cfg_q[`BIT_SYNC_SEL];
  assign mode_bits.carrier_mod_enable = cfg_q[`BIT_CARRIER_EN];
  assign mode_bits.xram_access_enable = cfg_q[`FLD_XRAM_HI:`FLD_XRAM_LO];
  assign carrier_pin_mask = cfg_q[`BIT_CARRIER_EN] ? epc_q : 8'h00;
  assign movx_enable = |cfg_q[`FLD_XRAM_HI:`FLD_XRAM_LO];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  sequence sfr_byte_write(logic [7:0] a);
    ce && sfr_wr && sfr_addr == a;
  endsequence
  sequence data_pointer_word_quiet;
    !data_pointer_word_load && !data_pointer_word_inc;
  endsequence
  baud_double_a: assert property (
    sfr_byte_write(`ADDR_POWER_CONTROL) |=> mode_bits.baud_double == $past(sfr_wdata[7]))
    else $error("baud double bit did not follow power-control write");
  power_control_reserved_a: assert property (
    ce && sfr_rd && sfr_addr == `ADDR_POWER_CONTROL |=> sfr_rdata[6:0] == 7'h00)
    else $error("power-control reserved bits did not read zero");
  data_pointer_word_low_a: assert property (
    sfr_byte_write(`ADDR_DATA_PTR_LOW) ##0 data_pointer_word_quiet ##0 !wr_dph |=>
      data_pointer_word[7:0] == $past(sfr_wdata) && $stable(data_pointer_word[15:8]))
    else $error("low data pointer byte write disturbed the high byte");
  data_pointer_word_word_a: assert property (
    ce && data_pointer_word_load && !wr_dpl && !wr_dph |=> data_pointer_word == $past(data_pointer_word_in))
    else $error("data pointer word load failed");
  data_pointer_word_inc_a: assert property (
    ce && data_pointer_word_inc && !data_pointer_word_load && !wr_dpl && !wr_dph
      |=> data_pointer_word == $past(data_pointer_word) + 16'h0001)
    else $error("data pointer increment carried wrongly");
  stack_write_a: assert property (
    sfr_byte_write(`ADDR_STACK_POINTER) |=> stack_pointer == $past(sfr_wdata))
    else $error("stack pointer write lost");
  cfg_modes_a: assert property (
    sfr_byte_write(`ADDR_CORE_CONFIG) |=>
      mode_bits.uart_checking_enable == $past(sfr_wdata[6])
      && mode_bits.sync_port_select == $past(sfr_wdata[5]))
    else $error("uart or sync port select did not follow config write");
  carrier_mask_a: assert property (
    !mode_bits.carrier_mod_enable |-> carrier_pin_mask == 8'h00)
    else $error("carrier modulation active while disabled");
  movx_gate_a: assert property (
    sfr_byte_write(`ADDR_CORE_CONFIG) |=> movx_enable == |$past(sfr_wdata[1:0]))
    else $error("movx enable does not follow config bits 1:0");
  parity_track_a: assert property (
    ce && acc_wr && !wr_acc |=> status_word[0] == ^$past(acc_in))
    else $error("parity flag does not track accumulator");
  flags_win_a: assert property (
    ce && flags_wr |=> status_word[7] == $past(flags_in.carry)
      && status_word[6] == $past(flags_in.aux_carry)
      && status_word[2] == $past(flags_in.overflow))
    else $error("alu flags not reflected in status word");
  bank_map_a: assert property (
    wreg_ram_addr == {status_word[4:3], wreg_idx})
    else $error("working register address not bank*8+n");
  op_timing_a: assert property (
    operand_src != core_regs_pkg::src_work_reg |-> op_cycles == 2'h2)
    else $error("memory operand not given two cycles");
  b_scratch_a: assert property (
    !(ce && (b_wr || wr_b)) |=> $stable(b_operand))
    else $error("b register changed without a write");
  freeze_a: assert property (
    !ce |=> $stable(stack_pointer) && $stable(data_pointer_word) && $stable(accumulator))
    else $error("state moved while clock enable low");
endmodule

// file: sim/exec_model.sv
// Stands in for software on the special-register bus; the bench drives the execution strobes itself
module exec_model (
  input wire logic clk,
  input wire logic [7:0] sfr_rdata,
  output logic [7:0] sfr_addr,
  output logic sfr_wr,
  output logic sfr_rd,
  output logic [7:0] sfr_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // Set by the bench to leave an idle cycle before every request
  bit slow = 1'b0;

  initial
  begin
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
  end

  // Software never writes ones to reserved places
  function automatic logic [7:0] legal(input logic [7:0] a, input logic [7:0] d);
    legal = d;
    if (a == 8'h87)
      legal = d & 8'h80;
    if (a == 8'haf)
      legal = (d | 8'h80) & 8'hf3;
  endfunction

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = legal(a, d);
    if (slow)
      @(posedge clk);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= v;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
    // Released lines show the inverse so a stale value is never trusted
    sfr_addr <= ~a;
    sfr_wdata <= ~v;
    #1;
  endtask

  task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
    if (slow)
      @(posedge clk);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    sfr_addr <= ~a;
    #1;
    d = sfr_rdata;
  endtask
endmodule

// file: sim/core_special_regs_tb.sv
module core_special_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, bit_addr, acc_in, b_in, stack_in, opcode_in;
  logic sfr_wr, sfr_rd, bit_wr, bit_val, acc_wr, b_wr, flags_wr, data_pointer_word_load, data_pointer_word_inc;
  logic stack_load, pc_advance, pc_load, opcode_load, wreg_wr, ram_lo_wr, movx_enable;
  logic [1:0] instr_len, op_cycles;
  logic [15:0] data_pointer_word_in, pc_target, data_pointer_word, program_counter;
  logic [2:0] wreg_idx;
  logic [4:0] wreg_ram_addr, ram_lo_addr;
  logic [7:0] wreg_wdata, wreg_rdata, ram_lo_wdata, ram_lo_rdata, accumulator, b_operand;
  logic [7:0] status_word, stack_pointer, opcode_holder, carrier_pin_mask, rd;
  core_regs_pkg::flag_upd_t flags_in;
  core_regs_pkg::op_src_t operand_src;
  core_regs_pkg::mode_bits_t mode_bits;
  int bad_count = 0;
  int num_checks = 0;

  always #2 clk = ~clk;

  exec_model pm (.clk, .sfr_rdata, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata);

  core_special_regs DUT (
    .clk, .arst_n, .ce, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .bit_wr, .bit_addr, .bit_val, .acc_wr, .acc_in, .b_wr, .b_in, .flags_wr, .flags_in,
    .data_pointer_word_load, .data_pointer_word_in, .data_pointer_word_inc, .stack_load, .stack_in, .pc_advance, .instr_len,
    .pc_load, .pc_target, .opcode_load, .opcode_in, .wreg_idx, .wreg_wr, .wreg_wdata,
    .wreg_rdata, .wreg_ram_addr, .ram_lo_addr, .ram_lo_wr, .ram_lo_wdata, .ram_lo_rdata,
    .operand_src, .op_cycles, .accumulator, .b_operand, .status_word, .data_pointer_word,
    .stack_pointer, .program_counter, .opcode_holder, .mode_bits, .carrier_pin_mask,
    .movx_enable
  );

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: byte got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: word got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    pm.sfr_read(a, rd);
    chk8(rd, exp);
  endtask

  // Strobes set at the previous edge are taken here, then all dropped together
  task automatic step;
    @(posedge clk);
    {acc_wr, b_wr, flags_wr, data_pointer_word_load, data_pointer_word_inc, stack_load} <= '0;
    {pc_advance, pc_load, opcode_load, wreg_wr, ram_lo_wr, bit_wr} <= '0;
    #1;
  endtask

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    #80000;
    bad_count++;
    finish_test;
  end

  initial
  begin
    {bit_wr, bit_val, acc_wr, b_wr, flags_wr, data_pointer_word_load, data_pointer_word_inc, stack_load} = '0;
    {pc_advance, pc_load, opcode_load, wreg_wr, ram_lo_wr, instr_len, wreg_idx} = '0;
    {bit_addr, acc_in, b_in, stack_in, opcode_in, wreg_wdata, ram_lo_wdata, ram_lo_addr} = '0;
    {data_pointer_word_in, pc_target} = '0;
    flags_in = '0;
    operand_src = core_regs_pkg::src_work_reg;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    chk8(stack_pointer, 8'h07);
    chk16(data_pointer_word, 16'h0000);
    chk16(program_counter, 16'h0000);
    chk8({2'b00, mode_bits}, 8'h01);
    chk8({7'h00, movx_enable}, 8'h01);
    rchk(8'h87, 8'h00);
    rchk(8'haf, 8'h81);
    pm.sfr_write(8'h81, 8'h30);
    rchk(8'h81, 8'h30);
    @(posedge clk);
    {stack_load, stack_in} <= {1'b1, 8'hff};
    step;
    chk8(stack_pointer, 8'hff);
    // A strobe taken while the clock enable is low must leave the register alone
    @(posedge clk);
    {ce, stack_load, stack_in} <= {1'b0, 1'b1, 8'h55};
    step;
    chk8(stack_pointer, 8'hff);
    @(posedge clk);
    ce <= 1'b1;
    // Halves written apart form one word
    pm.sfr_write(8'h82, 8'h34);
    pm.sfr_write(8'h83, 8'h12);
    chk16(data_pointer_word, 16'h1234);
    @(posedge clk);
    {data_pointer_word_load, data_pointer_word_in} <= {1'b1, 16'habff};
    step;
    @(posedge clk);
    data_pointer_word_inc <= 1'b1;
    step;
    // Increment must carry into the high byte
    chk16(data_pointer_word, 16'hac00);
    rchk(8'h82, 8'h00);
    rchk(8'h83, 8'hac);
    pm.sfr_write(8'h87, 8'hff);
    chk8({7'h00, mode_bits.baud_double}, 8'h01);
    rchk(8'h87, 8'h80);
    pm.slow = 1'b1;
    for (int i = 4; i < 7; i++)
    begin
      pm.sfr_write(8'haf, 8'h81 | (8'h01 << i));
      chk8({2'b00, mode_bits}, 8'h21 | (8'h01 << (i - 2)));
    end
    pm.slow = 1'b0;
    pm.sfr_write(8'h9f, 8'h5a);
    chk8(carrier_pin_mask, 8'h00);
    pm.sfr_write(8'haf, 8'h91);
    chk8(carrier_pin_mask, 8'h5a);
    for (int v = 0; v < 4; v++)
    begin
      pm.sfr_write(8'haf, 8'h80 | v[7:0]);
      chk8({7'h00, movx_enable}, {7'h00, v != 0});
    end
    // Unmapped place reads as zero
    rchk(8'h90, 8'h00);
    @(posedge clk);
    {pc_advance, instr_len} <= {1'b1, 2'h1};
    @(posedge clk);
    instr_len <= 2'h2;
    @(posedge clk);
    instr_len <= 2'h3;
    step;
    chk16(program_counter, 16'h0006);
    @(posedge clk);
    {pc_advance, pc_load, pc_target} <= {2'b11, 16'h1234};
    {opcode_load, opcode_in} <= {1'b1, 8'ha5};
    step;
    chk16(program_counter, 16'h1234);
    chk8(opcode_holder, 8'ha5);
    // A zero length still moves on by one byte
    @(posedge clk);
    {pc_advance, instr_len} <= {1'b1, 2'h0};
    step;
    chk16(program_counter, 16'h1235);
    @(posedge clk);
    {acc_wr, acc_in, b_wr, b_in} <= {1'b1, 8'h07, 1'b1, 8'h42};
    step;
    chk8({7'h00, status_word[0]}, 8'h01);
    chk8(b_operand, 8'h42);
    chk8(accumulator, 8'h07);
    rchk(8'hf0, 8'h42);
    pm.sfr_write(8'he0, 8'h03);
    chk8({7'h00, status_word[0]}, 8'h00);
    @(posedge clk);
    {flags_wr, flags_in} <= {1'b1, 3'b101};
    {bit_wr, bit_addr, bit_val} <= {1'b1, 8'hd5, 1'b1};
    step;
    chk8(status_word, 8'ha4);
    rchk(8'hd0, 8'ha4);
    // Carry set by the flag update must win over a same-cycle bit clear
    @(posedge clk);
    {flags_wr, flags_in} <= {1'b1, 3'b100};
    {bit_wr, bit_addr, bit_val} <= {1'b1, 8'hd7, 1'b0};
    step;
    chk8(status_word, 8'ha0);
    for (int b = 0; b < 4; b++)
    begin
      @(posedge clk);
      {bit_wr, bit_addr, bit_val} <= {1'b1, 8'hd3, b[0]};
      @(posedge clk);
      {bit_addr, bit_val} <= {8'hd4, b[1]};
      @(posedge clk);
      bit_wr <= 1'b0;
      {wreg_wr, wreg_idx, wreg_wdata} <= {1'b1, 3'h5, 8'h10 + b[7:0]};
      ram_lo_addr <= {b[1:0], 3'h5};
      step;
      chk8({3'h0, wreg_ram_addr}, {3'h0, b[1:0], 3'h5});
      chk8(ram_lo_rdata, 8'h10 + b[7:0]);
    end
    @(posedge clk);
    {ram_lo_wr, ram_lo_addr, ram_lo_wdata, wreg_idx} <= {1'b1, 5'h1f, 8'h77, 3'h7};
    step;
    chk8(wreg_rdata, 8'h77);
    for (int s = 0; s < 3; s++)
    begin
      @(posedge clk);
      operand_src <= core_regs_pkg::op_src_t'(s[1:0]);
      #1;
      chk8({6'h00, op_cycles}, (s == 0) ? 8'h01 : 8'h02);
    end
    finish_test;
  end
endmodule
